// >>> include/cmb_pkg.sv
// Purpose: Shared constants and types for the CAN message buffer block
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes:   Buffer storage carries no reset value on purpose
package cmb_pkg;
  // Bus geometry
  localparam int ADDR_W = 11;
  // Register indices (byte address = 4 * index)
  localparam logic [8:0] IX_CTRL0 = 9'h100;
  localparam logic [8:0] IX_CTRL1 = 9'h101;
  localparam logic [8:0] IX_BT0   = 9'h102;
  localparam logic [8:0] IX_BT1   = 9'h103;
  localparam logic [8:0] IX_RXFLG = 9'h104;
  localparam logic [8:0] IX_TXFLG = 9'h106;
  // Filter bytes 0x110..0x117, upper six index bits
  localparam logic [5:0] IX_FILT_HI = 6'h22;
  // Buffers 0x140..0x17F, upper three index bits
  localparam logic [2:0] IX_BUF_HI  = 3'h5;
  // Offsets inside a 16-byte buffer window
  localparam logic [3:0] OFS_LEN  = 4'hC;
  localparam logic [3:0] OFS_PRIO = 4'hD;
  // Control register 0 bit positions
  localparam int C0_SOFT_RESET_BIT = 0;
  localparam int C0_SLEEP_REQUEST  = 1;
  localparam int C0_SLEEP_ACK  = 2;
  localparam int C0_TLNK   = 3;
  localparam int C0_BUS_SYNCED_STATUS  = 4;
  localparam int C0_WAIT_STOP_BIT  = 5;
  // Values after reset and writable masks
  localparam logic [7:0] CTRL0_RST   = 8'h21;
  localparam logic [7:0] CTRL0_WMASK = 8'h2B;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] ACC_RST     = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'hFF;
  localparam logic [2:0] TXE_RST     = 3'h7;
  // Frame geometry, bits after start of frame
  localparam int         FRAME_BITS = 102;
  localparam logic [6:0] HDR_STD    = 7'h12;
  localparam logic [6:0] HDR_EXT    = 7'h26;
  localparam logic [3:0] MAX_BYTES  = 4'h8;
  // Bus idle detection counts
  localparam logic [3:0] RECESSIVE_RUN = 4'hB;
  localparam logic [7:0] BUS_OFF_STATE_RUNS   = 8'h80;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // One message buffer; byte k of the packed value is buffer offset k
  typedef struct packed {
    logic [7:0]      len;
    logic [7:0][7:0] data;
    logic [7:0]      id3;
    logic [7:0]      id2;
    logic [7:0]      id1;
    logic [7:0]      id0;
  } cmb_msg_t;
  // Bit engine states
  typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_FRAME, ST_TAIL} cmb_state_t;
endpackage

// >>> core/cmb_core.sv
// Purpose: CAN message buffers, transmit selection and module control 0
// Assumes: Bit stuffing, CRC and ACK are handled by nothing here
// Notes:   Frames are header plus data only
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module cmb_core #(
  parameter int ADDR_W = cmb_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // CAN pins
  input  wire logic              can_rx,
  output logic                   can_tx,
  // System side
  input  wire logic              wait_mode,
  input  wire logic              bus_off_state,
  input  wire logic              timer_port_pin,
  output logic                   timer_in,
  output logic                   mod_clk_en
);
  // Control and configuration
  logic [7:0]           ctrl0_r;        // Writable bits of control 0
  logic [7:0]           ctrl1_r;        // Control 1, soft-reset only
  logic [7:0]           bt0_r;          // Prescaler in bits 5:0
  logic [7:0]           bt1_r;          // Segment lengths
  logic [7:0]           filt_r [8];     // Accept 0-3, mask 4-7
  // Buffer storage: 0 receive, 1..3 transmit
  cmb_pkg::cmb_msg_t    buf_r [4];
  logic [7:0]           prio_r [3];     // Local priority per tx buffer
  // Flags
  logic                 rxf_r;          // Receive buffer full
  logic [2:0]           txe_r;          // Transmit buffer empty
  logic                 sleep_ack_r;        // Sleep acknowledge
  // Bit engine
  cmb_pkg::cmb_state_t  state_r;
  logic [6:0]           cnt_r;          // Bits sampled since start
  logic [cmb_pkg::FRAME_BITS-1:0] sh_r; // Sampled frame bits
  logic [cmb_pkg::FRAME_BITS-1:0] txv_r; // Frame being sent
  logic                 tx_on_r;        // Still owning the bus
  logic [1:0]           tx_sel_r;       // Buffer being sent
  logic                 can_tx_r;
  logic [5:0]           pc_r;           // Prescaler count
  logic [4:0]           q_r;            // Quantum within the bit
  logic [3:0]           rc_r;           // Consecutive recessive bits
  logic [7:0]           occ_r;          // Recessive runs while bus-off
  // Pin synchronisers: bit 0 bus receive, bit 1 timer port pin
  logic [1:0]           s1_r, s2_r, s3_r, pin_r;
  logic                 rx_d_r;
  // Outputs
  logic                 timer_in_r;
  logic                 mod_clk_en_r;
  // AXI slave state
  logic                 awready_r, wready_r, bvalid_r;
  logic                 arready_r, rvalid_r;
  logic [1:0]           bresp_r, rresp_r;
  logic [31:0]          rdata_r;
  logic                 aw_have_r, w_have_r, wstb_r;
  logic [8:0]           wix_r;
  logic [7:0]           wdata_r;

  // Combinational helpers
  logic                 soft_reset_bit, rx_s, run, tq_tick, smp, txpt, hsync;
  logic [4:0]           ts1, last_q;
  logic                 wr_go, rx_store, fdone, found, accept;
  logic [2:0]           done_vec;
  logic [1:0]           win;
  logic [6:0]           hdr, flen;
  logic [3:0]           dlc, nb;
  logic                 ide, rtr;
  cmb_pkg::cmb_msg_t    rx_msg;
  logic [8:0]           rix;
  logic [7:0]           rd_val;

  assign soft_reset_bit = ctrl0_r[cmb_pkg::C0_SOFT_RESET_BIT];
  assign rx_s   = pin_r[0];
  assign run    = mod_clk_en_r;
  assign wr_go  = aw_have_r & w_have_r & ~bvalid_r;
  assign rix    = s_axi_araddr[ADDR_W-1:2];

  // Outputs straight from flip-flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign can_tx        = can_tx_r;
  assign timer_in      = timer_in_r;
  assign mod_clk_en    = mod_clk_en_r;

  // Buffer to bus bit order, identifier MSB first
  function automatic logic [cmb_pkg::FRAME_BITS-1:0] pack(
    input cmb_pkg::cmb_msg_t m);
    logic [cmb_pkg::FRAME_BITS-1:0] v;
    logic [10:0] idh;
    logic [17:0] idl;
    int h;
    v   = '0;                           // Reserved bits go dominant
    idh = {m.id0, m.id1[7:5]};          // 11-bit head
    idl = {m.id1[2:0], m.id2, m.id3[7:1]};
    for (int k = 0; k < 11; k++) v[k] = idh[10-k];
    v[11] = m.id1[4];                   // Remote or substitute
    v[12] = m.id1[3];                   // Format flag
    h = 18;
    if (m.id1[3]) begin                 // Extended tail
      for (int k = 0; k < 18; k++) v[13+k] = idl[17-k];
      v[31] = m.id3[0];
      h = 38;
    end
    for (int k = 0; k < 4; k++) v[h-4+k] = m.len[3-k];
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 8; j++) v[h+8*i+j] = m.data[i][7-j];
    end
    return v;
  endfunction

  // Bus bit order back to buffer layout
  function automatic cmb_pkg::cmb_msg_t unpack(
    input logic [cmb_pkg::FRAME_BITS-1:0] v);
    cmb_pkg::cmb_msg_t m;
    logic [10:0] idh;
    logic [17:0] idl;
    int h;
    m = '0;
    for (int k = 0; k < 11; k++) idh[10-k] = v[k];
    for (int k = 0; k < 18; k++) idl[17-k] = v[13+k];
    m.id0 = idh[10:3];
    m.id1 = {idh[2:0], v[11], v[12], 3'h0}; // Standard
    h = 18;
    if (v[12]) begin                    // Extended
      m.id1[2:0] = idl[17:15];
      m.id2      = idl[14:7];
      m.id3      = {idl[6:0], v[31]};
      h = 38;
    end
    for (int k = 0; k < 4; k++) m.len[3-k] = v[h-4+k];
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 8; j++) m.data[i][7-j] = v[h+8*i+j];
    end
    return m;
  endfunction

  // Mapped register indices
  function automatic logic hit(input logic [8:0] ix);
    return ix[8:6] == cmb_pkg::IX_BUF_HI
        || ix[8:3] == cmb_pkg::IX_FILT_HI
        || (ix >= cmb_pkg::IX_CTRL0 && ix <= cmb_pkg::IX_RXFLG)
        || ix == cmb_pkg::IX_TXFLG;
  endfunction

  // Pin synchronisers; a change counts once stages two and three agree
  for (genvar i = 0; i < 2; i++) begin : g_pin
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        s1_r[i]  <= 1'b1;
        s2_r[i]  <= 1'b1;
        s3_r[i]  <= 1'b1;
        pin_r[i] <= 1'b1;
      end else begin
        s1_r[i] <= (i == 0) ? can_rx : timer_port_pin;
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          pin_r[i] <= s3_r[i];
        end
      end
    end
  end

  // Decode of the sampled frame; valid once cnt reaches the header end
  always_comb begin
    ide  = sh_r[12];
    hdr  = ide ? cmb_pkg::HDR_EXT : cmb_pkg::HDR_STD;
    rtr  = ide ? sh_r[31] : sh_r[11];
    dlc  = ide ? {sh_r[34], sh_r[35], sh_r[36], sh_r[37]}
               : {sh_r[14], sh_r[15], sh_r[16], sh_r[17]};
    // Codes above eight still move eight bytes
    nb   = (dlc > cmb_pkg::MAX_BYTES) ? cmb_pkg::MAX_BYTES : dlc;
    if (rtr) nb = 4'h0;
    flen = hdr + {nb, 3'h0};
  end

  // Format flag is unknown until bit 12 lands; gate on the short header
  assign fdone  = (state_r == cmb_pkg::ST_FRAME)
                  && cnt_r >= cmb_pkg::HDR_STD && cnt_r >= hdr
                  && cnt_r == flen;
  assign rx_msg = unpack(sh_r);
  // Mask bit set means do not care
  assign accept = (({rx_msg.id0, rx_msg.id1, rx_msg.id2, rx_msg.id3}
                   ^ {filt_r[0], filt_r[1], filt_r[2], filt_r[3]})
                   & ~{filt_r[4], filt_r[5], filt_r[6], filt_r[7]})
                  == 32'h0000_0000;
  // A full receive buffer is never overwritten under a reader
  assign rx_store = fdone & ~tx_on_r & accept & ~rxf_r;
  assign done_vec = (fdone && tx_on_r) ? 3'(3'h1 << tx_sel_r) : 3'h0;

  // Transmit buffer selection; strict compare keeps the lower index
  always_comb begin
    win   = 2'h0;
    found = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (!txe_r[i] && (!found || prio_r[i] < prio_r[win])) begin
        win   = 2'(i);
        found = 1'b1;
      end
    end
  end

  // Bit timing: sync quantum, segment 1 to sample, segment 2 to end
  assign ts1     = {1'b0, bt1_r[3:0]} + 5'h01;
  assign last_q  = ts1 + {2'h0, bt1_r[6:4]} + 5'h01;
  assign tq_tick = run && pc_r == bt0_r[5:0];
  assign smp     = tq_tick && q_r == ts1;
  assign txpt    = tq_tick && q_r == last_q;
  // Hard sync on a foreign falling edge while the bus is idle
  assign hsync   = state_r == cmb_pkg::ST_IDLE && !tx_on_r
                   && rx_d_r && !rx_s;

  // Prescaler and quantum counters; stalled while the clock is stopped
  always_ff @(posedge clk) begin
    if (!rst_n || soft_reset_bit || hsync) begin
      pc_r <= 6'h00;
      q_r  <= 5'h00;
    end else if (tq_tick) begin
      pc_r <= 6'h00;
      q_r  <= (q_r == last_q) ? 5'h00 : q_r + 5'h01;
    end else if (run) begin
      pc_r <= pc_r + 6'h01;
    end
  end

  // Edge history of the synchronised receive level
  always_ff @(posedge clk) begin
    if (!rst_n) rx_d_r <= 1'b1;
    else        rx_d_r <= rx_s;
  end

  // Recessive run counter and bus-off run count
  always_ff @(posedge clk) begin
    if (!rst_n || soft_reset_bit) begin
      rc_r  <= 4'h0;
      occ_r <= 8'h00;
    end else if (fdone) begin
      rc_r <= 4'h0;
    end else if (smp) begin
      if (!rx_s) begin
        rc_r <= 4'h0;
      end else if (rc_r + 4'h1 == cmb_pkg::RECESSIVE_RUN
                   && state_r == cmb_pkg::ST_OFF && bus_off_state) begin
        rc_r <= 4'h0;
        if (occ_r != cmb_pkg::BUS_OFF_STATE_RUNS) occ_r <= occ_r + 8'h01;
      end else if (rc_r != cmb_pkg::RECESSIVE_RUN) begin
        rc_r <= rc_r + 4'h1;
      end
    end
  end

  // Bit engine; soft reset aborts any frame at once
  always_ff @(posedge clk) begin
    if (!rst_n || soft_reset_bit) begin
      state_r  <= cmb_pkg::ST_OFF;
      cnt_r    <= 7'h00;
      tx_on_r  <= 1'b0;
      tx_sel_r <= 2'h0;
      can_tx_r <= 1'b1;
    end else begin
      unique case (state_r)
        cmb_pkg::ST_OFF: begin
          // Synchronise after enough recessive bits
          if (bus_off_state ? occ_r == cmb_pkg::BUS_OFF_STATE_RUNS
                            : rc_r == cmb_pkg::RECESSIVE_RUN) begin
            state_r <= cmb_pkg::ST_IDLE;
          end
        end
        cmb_pkg::ST_IDLE: begin
          // Selection happens at the bit just before start
          if (txpt && found && !sleep_ack_r) begin
            tx_on_r  <= 1'b1;
            tx_sel_r <= win;
            txv_r    <= pack(buf_r[2'(win + 2'h1)]);
            can_tx_r <= 1'b0;
          end
          // Asleep nodes ignore the bus until sleep is released
          if (smp && !rx_s && !sleep_ack_r) begin
            state_r <= cmb_pkg::ST_FRAME;
            cnt_r   <= 7'h00;
          end
        end
        cmb_pkg::ST_FRAME: begin
          if (fdone) begin
            state_r  <= cmb_pkg::ST_TAIL;
            tx_on_r  <= 1'b0;
            can_tx_r <= 1'b1;
          end else begin
            if (txpt) begin
              can_tx_r <= tx_on_r ? txv_r[cnt_r] : 1'b1;
            end
            if (smp) begin
              sh_r[cnt_r] <= rx_s;
              cnt_r       <= cnt_r + 7'h01;
              // Lost arbitration or bit error: fall back to receiving
              if (tx_on_r && can_tx_r != rx_s) begin
                tx_on_r <= 1'b0;
              end
            end
          end
        end
        cmb_pkg::ST_TAIL: begin
          if (rc_r == cmb_pkg::RECESSIVE_RUN) state_r <= cmb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Control register 0; clearing soft reset touches nothing else
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl0_r <= cmb_pkg::CTRL0_RST;
    end else if (wr_go && wstb_r && wix_r == cmb_pkg::IX_CTRL0) begin
      if (soft_reset_bit) begin
        if (!wdata_r[cmb_pkg::C0_SOFT_RESET_BIT]) begin
          ctrl0_r[cmb_pkg::C0_SOFT_RESET_BIT] <= 1'b0;
        end
      end else if (wdata_r[cmb_pkg::C0_SOFT_RESET_BIT]) begin
        ctrl0_r <= cmb_pkg::CTRL0_RST;
      end else begin
        ctrl0_r <= wdata_r & cmb_pkg::CTRL0_WMASK;
      end
    end
  end

  // Configuration written only during soft reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl1_r <= cmb_pkg::CTRL_RST;
      bt0_r   <= cmb_pkg::CTRL_RST;
      bt1_r   <= cmb_pkg::CTRL_RST;
      for (int i = 0; i < 4; i++) begin
        filt_r[i]   <= cmb_pkg::ACC_RST;
        filt_r[i+4] <= cmb_pkg::MASK_RST;
      end
    end else if (wr_go && wstb_r && soft_reset_bit) begin
      if (wix_r == cmb_pkg::IX_CTRL1) ctrl1_r <= wdata_r;
      if (wix_r == cmb_pkg::IX_BT0)   bt0_r   <= wdata_r;
      if (wix_r == cmb_pkg::IX_BT1)   bt1_r   <= wdata_r;
      if (wix_r[8:3] == cmb_pkg::IX_FILT_HI) filt_r[wix_r[2:0]] <= wdata_r;
    end
  end

  // Flags; a hardware set beats a same-cycle software clear
  always_ff @(posedge clk) begin
    if (!rst_n || soft_reset_bit) begin
      rxf_r <= 1'b0;
      txe_r <= cmb_pkg::TXE_RST;
    end else begin
      rxf_r <= rx_store | (rxf_r & ~(wr_go && wstb_r && wdata_r[0]
               && wix_r == cmb_pkg::IX_RXFLG));
      // Writing one clears empty and queues the buffer
      txe_r <= done_vec | (txe_r & ~((wr_go && wstb_r
               && wix_r == cmb_pkg::IX_TXFLG) ? wdata_r[2:0] : 3'h0));
    end
  end

  // Sleep acknowledge once idle with nothing queued
  always_ff @(posedge clk) begin
    if (!rst_n || soft_reset_bit) begin
      sleep_ack_r <= 1'b0;
    end else begin
      sleep_ack_r <= ctrl0_r[cmb_pkg::C0_SLEEP_REQUEST] && (sleep_ack_r
                 || (state_r == cmb_pkg::ST_IDLE && &txe_r
                     && !tx_on_r));
    end
  end

  // Clock stop request and timer input selection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mod_clk_en_r <= 1'b1;
      timer_in_r   <= 1'b0;
    end else begin
      mod_clk_en_r <= !(wait_mode && ctrl0_r[cmb_pkg::C0_WAIT_STOP_BIT]);
      timer_in_r   <= ctrl0_r[cmb_pkg::C0_TLNK] ? fdone : pin_r[1];
    end
  end

  // Buffer storage; no reset so contents start undefined
  always_ff @(posedge clk) begin
    // Receive buffer takes no bus writes
    if (wr_go && wstb_r && wix_r[8:6] == cmb_pkg::IX_BUF_HI
        && wix_r[5:4] != 2'h0) begin
      if (wix_r[3:0] <= cmb_pkg::OFS_LEN) begin
        buf_r[wix_r[5:4]][{wix_r[3:0], 3'h0} +: 8] <= wdata_r;
      end else if (wix_r[3:0] == cmb_pkg::OFS_PRIO) begin
        prio_r[wix_r[5:4] - 2'h1] <= wdata_r;
      end
    end
    if (rx_store) buf_r[0] <= rx_msg;
  end

  // Read data selection
  always_comb begin
    rd_val = 8'h00;
    if (rix[8:6] == cmb_pkg::IX_BUF_HI) begin
      if (rix[3:0] <= cmb_pkg::OFS_LEN) begin
        rd_val = buf_r[rix[5:4]][{rix[3:0], 3'h0} +: 8];
      end else if (rix[3:0] == cmb_pkg::OFS_PRIO && rix[5:4] != 2'h0) begin
        rd_val = prio_r[rix[5:4] - 2'h1];
      end
    end else if (rix[8:3] == cmb_pkg::IX_FILT_HI) begin
      rd_val = filt_r[rix[2:0]];
    end else begin
      case (rix)
        cmb_pkg::IX_CTRL0: begin
          rd_val = ctrl0_r;
          rd_val[cmb_pkg::C0_BUS_SYNCED_STATUS] = state_r != cmb_pkg::ST_OFF;
          rd_val[cmb_pkg::C0_SLEEP_ACK] = sleep_ack_r;
        end
        cmb_pkg::IX_CTRL1: rd_val = ctrl1_r;
        cmb_pkg::IX_BT0:   rd_val = bt0_r;
        cmb_pkg::IX_BT1:   rd_val = bt1_r;
        cmb_pkg::IX_RXFLG: rd_val = {7'h00, rxf_r};
        cmb_pkg::IX_TXFLG: rd_val = {5'h00, txe_r};
        default:           rd_val = 8'h00;
      endcase
    end
  end

  // AXI4-Lite write side: one write in flight, address and data any order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= cmb_pkg::RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      wix_r     <= 9'h000;
      wdata_r   <= 8'h00;
      wstb_r    <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
        wix_r     <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && wready_r) begin
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata[7:0];
        wstb_r   <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        bvalid_r  <= 1'b1;
        bresp_r   <= hit(wix_r) ? cmb_pkg::RESP_OKAY : cmb_pkg::RESP_SLVERR;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read side: data registered one cycle after the address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= cmb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h00_0000, hit(rix) ? rd_val : 8'h00};
      rresp_r   <= hit(rix) ? cmb_pkg::RESP_OKAY : cmb_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end
endmodule

// >>> testbench/cmb_monitor.sv
// Purpose: Port checker for the message buffer core
// Assumes: Bus answer timing as agreed for the core
// Notes:   Attached by the bind at the foot
`timescale 1ns/1ps
module cmb_monitor #(parameter int ADDR_W = 11) (
  // Watched ports
  input wire logic              clk, rst_n, wait_mode, mod_clk_en,
  input wire logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic              s_axi_wready, s_axi_bvalid, s_axi_arvalid,
  input wire logic              s_axi_arready, s_axi_rvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wr_ans; s_axi_awvalid && s_axi_wvalid && s_axi_awready
    && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("late b");
  property p_aw_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_blk: assert property (p_aw_blk) else $error("aw open");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("late r");
  property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_blk: assert property (p_ar_blk) else $error("ar open");
  property p_rd_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("upper");
  property p_unmap; s_axi_arvalid && s_axi_arready && s_axi_araddr
    [ADDR_W-1:2] < 9'h100 |=> s_axi_rresp == cmb_pkg::RESP_SLVERR; endproperty
  a_unmap: assert property (p_unmap) else $error("no error");
  property p_clk_run; !wait_mode |=> mod_clk_en; endproperty
  a_clk_run: assert property (p_clk_run) else $error("gated");
  property p_clk_stop; $fell(mod_clk_en) |-> $past(wait_mode); endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("stop");
endmodule
bind cmb_core cmb_monitor #(.ADDR_W(ADDR_W)) u_cmb_monitor (.*);

// >>> testbench/cmb_bus_node.sv
// Purpose: Other node on the bus, wired-AND with our transmitter
// Assumes: Recessive is 1, no transceiver delay
// Notes:   Holding dominant models a busy bus that blocks sync
`timescale 1ns/1ps
module cmb_bus_node (
  // Wire side
  input  wire logic can_tx,
  input  wire logic hold_dom,
  output logic      can_rx
);
  // Dominant wins; released bus rests recessive through the pull-up
  assign can_rx = can_tx & ~hold_dom;
endmodule

// >>> testbench/cmb_core_tb_top.sv
// Purpose: Self-checking bench for the message buffer core
// Assumes: Bus timing per the core hand-over
// Notes:   Fast bit timing keeps frames short
`timescale 1ns/1ps
module cmb_core_tb_top;
  logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    s_axi_rready, can_rx, can_tx, wait_mode, bus_off_state, timer_port_pin,
    timer_in, mod_clk_en, hold_dom;
  logic [10:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, seed = 32'h0000_6B32;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  mem [3][14];
  int failures, comparisons, cyc;
  cmb_core u_cmb_core (.*);
  cmb_bus_node u_cmb_bus_node (.*);
  initial begin clk = 0; forever #5 clk = ~clk; end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5; return seed;
  endfunction
  // Lowest priority value wins, strict compare keeps lowest index on ties
  function automatic int win();
    win = 0;
    for (int b = 1; b < 3; b++) if (mem[b][13] < mem[win][13]) win = b;
  endfunction
  task automatic chk(logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [8:0] ix, logic [7:0] v);
    bit ad, wd;
    @(posedge clk);
    s_axi_awaddr <= {ix, 2'b0}; s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready) begin wd = 1; s_axi_wvalid <= 0; end
    end while (!(ad && wd));
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task automatic rd(logic [8:0] ix);
    @(posedge clk);
    s_axi_araddr <= {ix, 2'b0}; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
  endtask
  task automatic rc(logic [8:0] ix, logic [31:0] e); rd(ix); chk(d, e);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin failures++; wrap_up(); end
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, wait_mode, bus_off_state, timer_port_pin, hold_dom} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0; s_axi_wstrb = 4'hF;
    repeat (20) @(posedge clk);
    rst_n <= 1;
    rc(cmb_pkg::IX_CTRL0, 32'h21);
    wait_mode <= 1; repeat (3) @(posedge clk);
    chk(mod_clk_en, 0);
    wait_mode <= 0; timer_port_pin <= 1; repeat (6) @(posedge clk);
    chk(mod_clk_en, 1);
    chk(timer_in, 1);
    $display("test control done");
    // Random buffers; SRR forced high, length kept at 0 or 8
    for (int b = 0; b < 3; b++) for (int k = 0; k < 14; k++) begin
      mem[b][k] = 8'(rnd());
      if (k == 1) mem[b][k][4] = 1'b1;
      if (k == 12) mem[b][k] &= 8'h08;
      wr(9'h150 + 9'(b * 16 + k), mem[b][k]);
    end
    mem[2][13] = mem[1][13]; wr(9'h17D, mem[2][13]);
    for (int b = 0; b < 3; b++) for (int k = 0; k < 16; k++)
      rc(9'h150 + 9'(b * 16 + k), k < 14 ? mem[b][k] : 8'h0);
    rc(9'h14D, 0);
    rd(9'h140); rd(9'h140); wr(9'h140, 8'h5A); rc(9'h140, d);
    rd(0); chk(r, cmb_pkg::RESP_SLVERR);
    $display("test buffers done");
    // Sample point must trail the pin sync delay to see our own bits
    wr(cmb_pkg::IX_BT0, 8'h00); wr(cmb_pkg::IX_BT1, 8'h17);
    hold_dom <= 1;
    wr(cmb_pkg::IX_CTRL0, 8'h20);
    wr(cmb_pkg::IX_BT1, 8'h12); rc(cmb_pkg::IX_BT1, 32'h17);
    repeat (100) @(posedge clk);
    rc(cmb_pkg::IX_CTRL0, 32'h20);
    hold_dom <= 0; repeat (200) @(posedge clk);
    rc(cmb_pkg::IX_CTRL0, 32'h30);
    $display("test sync done");
    wr(cmb_pkg::IX_TXFLG, 8'h07); d = 0;
    for (int i = 0; i < 1000 && d == 0; i++) rd(cmb_pkg::IX_TXFLG);
    chk(d, 32'h1 << win());
    for (int i = 0; i < 2000 && d !== 7; i++) rd(cmb_pkg::IX_TXFLG);
    chk(d, 7);
    wr(cmb_pkg::IX_CTRL0, 8'h22);
    // Tail of the last frame still runs, so no acknowledge yet
    rc(cmb_pkg::IX_CTRL0, 32'h32);
    repeat (200) @(posedge clk);
    rc(cmb_pkg::IX_CTRL0, 32'h36);
    $display("test transmit done");
    wrap_up();
  end
endmodule
